// file: core/supply_monitor_defs.vh
// Purpose: shared constants for the supply monitor and fault response block
// Assumes: 100 MHz mclk
// Notes:   bit positions are within the eight-bit monitor status words
`ifndef SUPPLY_MONITOR_DEFS_VH
`define SUPPLY_MONITOR_DEFS_VH

// ****************************************************************
// status bit positions
// ****************************************************************
`define STAT1_BAT_UV      6
`define STAT1_BAT_OV      7
`define STAT2_IO_UV       2
`define STAT2_IO_OV       3
`define STAT2_XCVR_UV     4
`define STAT2_XCVR_OV     5
`define STAT2_PRE_UV      6
`define STAT2_PRE_OV      7
`define STAT_RESET        8'h00

// ****************************************************************
// rail indices into the comparator vectors
// ****************************************************************
`define RAIL_BAT          0
`define RAIL_PRE          1
`define RAIL_XCVR         2
`define RAIL_IO           3
`define RAIL_COUNT        4

// ****************************************************************
// device states
// ****************************************************************
`define ST_OFF            3'h0
`define ST_SELFTEST       3'h1
`define ST_DIAGNOSTIC     3'h2
`define ST_ACTIVE         3'h3
`define ST_SAFE           3'h4
`define ST_RESET          3'h5
`define ST_STANDBY        3'h6

// ****************************************************************
// timing
// ****************************************************************
`define FILTER_NS         1000
`define FILTER_CYCLES     ((`FILTER_NS + 9) / 10)
`define TOGGLE_HALF_NS    200
`define TOGGLE_HALF_CYCLES ((`TOGGLE_HALF_NS + 9) / 10)
`define TOGGLE_PAIRS      3
`define WD_FAIL_LIMIT     3'h5

`endif

// file: core/comparator_filter.v
// Purpose: two-flop synchroniser and glitch filter for one comparator output
// Assumes: raw comparator is asynchronous to mclk
// Notes:   output changes only after the input holds steady for the filter count
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.vh"

module comparator_filter #(
   parameter FILTER_CYCLES = `FILTER_CYCLES
) (
   input  wire mclk,
   input  wire rstn,
   input  wire raw,
   output reg  filtered
);

   reg        sync_a;
   reg        sync_b;
   reg [15:0] count;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync_a   <= 1'b0;
         sync_b   <= 1'b0;
         count    <= 16'h0000;
         filtered <= 1'b0;
      end else begin
         sync_a <= raw;
         sync_b <= sync_a;
         // short transients restart the count and never reach the output
         if (sync_b == filtered) begin
            count <= 16'h0000;
         end else if (count == FILTER_CYCLES[15:0] - 16'h0001) begin
            count    <= 16'h0000;
            filtered <= sync_b;
         end else begin
            count <= count + 16'h0001;
         end
      end
   end

endmodule
`default_nettype wire

// file: core/comparator_self_test.v
// Purpose: drives emulated under/over inputs and checks the toggle pattern
// Assumes: forced comparators answer through the same glitch filters
// Notes:   pass needs every comparator to follow each forced edge
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.vh"

module comparator_self_test #(
   parameter N           = `RAIL_COUNT,
   parameter HALF_CYCLES = `TOGGLE_HALF_CYCLES + `FILTER_CYCLES + 2,
   parameter PAIRS       = `TOGGLE_PAIRS
) (
   input  wire         mclk,
   input  wire         rstn,
   input  wire         start,
   input  wire [N-1:0] uv_seen,
   input  wire [N-1:0] ov_seen,
   output reg          force_active,
   output reg          force_level,
   output reg          done,
   output reg          fail
);

   reg [15:0] timer;
   reg [3:0]  edges;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         force_active <= 1'b0;
         force_level  <= 1'b0;
         done         <= 1'b0;
         fail         <= 1'b0;
         timer        <= 16'h0000;
         edges        <= 4'h0;
      end else begin
         done <= 1'b0;
         if (!force_active) begin
            if (start) begin
               force_active <= 1'b1;
               force_level  <= 1'b1;
               fail         <= 1'b0;
               timer        <= 16'h0000;
               edges        <= 4'h0;
            end
         end else if (timer == HALF_CYCLES[15:0] - 16'h0001) begin
            timer <= 16'h0000;
            // sample at the end of each half period: all must match the forced level
            if ((uv_seen != {N{force_level}}) || (ov_seen != {N{force_level}})) begin
               fail <= 1'b1;
            end
            if (edges == PAIRS[3:0] * 4'h2 - 4'h1) begin
               force_active <= 1'b0;
               force_level  <= 1'b0;
               done         <= 1'b1;
            end else begin
               edges       <= edges + 4'h1;
               force_level <= ~force_level;
            end
         end else begin
            timer <= timer + 16'h0001;
         end
      end
   end

endmodule
`default_nettype wire

// file: core/supply_monitor_fault_response.v
// Summary of operation
// - analog self-test starts by itself once the pre-regulator rail is above undervoltage
// - analog or logic self-test failure sends the state controller to SAFE
// - enable-drive output needs count, control bit and all fault signals permitting
// - each monitor flag reads 0 in tolerance and 1 out of tolerance
// - every comparator output is glitch filtered before it reaches a flag
// - comparator test runs at start-up or on request in DIAGNOSTIC or ACTIVE
// - test forces under and over levels, each comparator toggles, pattern checked
// - forced toggles during the test never count as real rail events
// - battery undervoltage sets status one bit 6, STANDBY, reset and drive low
// - battery overvoltage sets status one bit 7, RESET only when mask is zero
// - pre-regulator under and over set status two bits 6 and 7
// - transceiver under sets status two bit 4, over sets bit 5, drive low
// - I/O rail at 5 V undervoltage sets status two bit 2
// - I/O rail overvoltage sets status two bit 3 and forces drive low
//
// Purpose: digital side of a multi-rail supply supervisor
// Assumes: comparators, self-test result of logic and control bits arrive as ports
// Notes:   flags are live levels; forced test results never reach them
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.vh"

module supply_monitor_fault_response #(
   parameter N             = `RAIL_COUNT,
   parameter FILTER_CYCLES = `FILTER_CYCLES
) (
   input  wire         mclk,
   input  wire         rstn,
   input  wire [N-1:0] uv_comparator,
   input  wire [N-1:0] ov_comparator,
   input  wire         io_rail_5v,
   input  wire         logic_self_test_done,
   input  wire         logic_self_test_fail,
   input  wire         self_test_request,
   input  wire         diag_exit_request,
   input  wire         restart_request,
   input  wire         battery_overvoltage_mask,
   input  wire         enable_drive_bit,
   input  wire [2:0]   watchdog_failure_count,
   input  wire         internal_fault,
   output reg  [7:0]   monitor_status_one,
   output reg  [7:0]   monitor_status_two,
   output reg  [2:0]   device_state,
   output wire         built_in_self_test_busy,
   output wire         comparator_force_active,
   output wire         comparator_force_level,
   output reg          analog_self_test_fail,
   output reg          mcu_reset_output,
   output reg          enable_drive_output
);

   // ****************************************************************
   // comparator filtering
   // ****************************************************************
   wire [N-1:0] uv_filt;
   wire [N-1:0] ov_filt;

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : filt
         comparator_filter #(
            .FILTER_CYCLES (FILTER_CYCLES)
         ) uv_f (
            .mclk     (mclk),
            .rstn     (rstn),
            .raw      (uv_comparator[g]),
            .filtered (uv_filt[g])
         );
         comparator_filter #(
            .FILTER_CYCLES (FILTER_CYCLES)
         ) ov_f (
            .mclk     (mclk),
            .rstn     (rstn),
            .raw      (ov_comparator[g]),
            .filtered (ov_filt[g])
         );
      end
   endgenerate

   // ****************************************************************
   // comparator self-test
   // ****************************************************************
   reg  test_start;
   wire test_done;
   wire test_fail;
   reg  test_running;
   reg  hold_off;
   reg  [15:0] settle;

   comparator_self_test #(
      .N           (N),
      .HALF_CYCLES (`TOGGLE_HALF_CYCLES + FILTER_CYCLES + 2)
   ) cst (
      .mclk         (mclk),
      .rstn         (rstn),
      .start        (test_start),
      .uv_seen      (uv_filt),
      .ov_seen      (ov_filt),
      .force_active (comparator_force_active),
      .force_level  (comparator_force_level),
      .done         (test_done),
      .fail         (test_fail)
   );

   // forced levels drain through the filters after the test ends, so flags
   // stay frozen for the filter count plus four more cycles
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         test_running <= 1'b0;
         hold_off     <= 1'b0;
         settle       <= 16'h0000;
      end else begin
         if (test_start) begin
            test_running <= 1'b1;
            hold_off     <= 1'b1;
         end else if (test_done) begin
            test_running <= 1'b0;
            settle       <= 16'h0000;
         end else if (hold_off && !test_running) begin
            if (settle == FILTER_CYCLES[15:0] + 16'h0003) begin
               hold_off <= 1'b0;
            end else begin
               settle <= settle + 16'h0001;
            end
         end
      end
   end

   assign built_in_self_test_busy = hold_off || (device_state == `ST_SELFTEST);

   // ****************************************************************
   // live rail events, masked during the self-test
   // ****************************************************************
   wire [N-1:0] uv_live = hold_off ? {N{1'b0}} : uv_filt;
   wire [N-1:0] ov_live = hold_off ? {N{1'b0}} : ov_filt;
   wire         io_uv   = uv_live[`RAIL_IO] & io_rail_5v;

   // ****************************************************************
   // status flags
   // ****************************************************************
   reg [7:0] next_stat1;
   reg [7:0] next_stat2;

   always @* begin
      next_stat1 = `STAT_RESET;
      next_stat2 = `STAT_RESET;
      // during the test the flags keep their last real value
      if (hold_off) begin
         next_stat1 = monitor_status_one;
         next_stat2 = monitor_status_two;
      end else begin
         next_stat1[`STAT1_BAT_UV]  = uv_live[`RAIL_BAT];
         next_stat1[`STAT1_BAT_OV]  = ov_live[`RAIL_BAT];
         next_stat2[`STAT2_PRE_UV]  = uv_live[`RAIL_PRE];
         next_stat2[`STAT2_PRE_OV]  = ov_live[`RAIL_PRE];
         next_stat2[`STAT2_XCVR_UV] = uv_live[`RAIL_XCVR];
         next_stat2[`STAT2_XCVR_OV] = ov_live[`RAIL_XCVR];
         next_stat2[`STAT2_IO_UV]   = io_uv;
         next_stat2[`STAT2_IO_OV]   = ov_live[`RAIL_IO];
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         monitor_status_one <= `STAT_RESET;
         monitor_status_two <= `STAT_RESET;
      end else begin
         monitor_status_one <= next_stat1;
         monitor_status_two <= next_stat2;
      end
   end

   // ****************************************************************
   // device state controller
   // ****************************************************************
   reg [2:0] next_state;
   reg       logic_done_seen;
   reg       bat_uv_event;
   reg       bat_ov_event;

   always @* begin
      bat_uv_event = uv_live[`RAIL_BAT];
      bat_ov_event = ov_live[`RAIL_BAT] & ~battery_overvoltage_mask;
   end

   always @* begin
      next_state = device_state;
      test_start = 1'b0;
      case (device_state)
         `ST_OFF: begin
            // pre-regulator above its undervoltage threshold
            if (!uv_filt[`RAIL_PRE]) begin
               next_state = `ST_SELFTEST;
               test_start = 1'b1;
            end
         end
         `ST_SELFTEST: begin
            if (test_done && test_fail) begin
               next_state = `ST_SAFE;
            end else if (logic_self_test_done && logic_self_test_fail) begin
               next_state = `ST_SAFE;
            end else if (!test_running && logic_done_seen) begin
               next_state = analog_self_test_fail ? `ST_SAFE : `ST_DIAGNOSTIC;
            end
         end
         `ST_DIAGNOSTIC, `ST_ACTIVE: begin
            if (test_done && test_fail) begin
               next_state = `ST_SAFE;
            end else if (self_test_request && !test_running) begin
               test_start = 1'b1;
            end else if (device_state == `ST_DIAGNOSTIC && diag_exit_request) begin
               next_state = `ST_ACTIVE;
            end
         end
         `ST_SAFE, `ST_RESET: begin
            if (restart_request) begin
               next_state = `ST_OFF;
            end
         end
         `ST_STANDBY: begin
            if (!uv_live[`RAIL_BAT]) begin
               next_state = `ST_OFF;
            end
         end
         default: begin
            next_state = `ST_OFF;
         end
      endcase
      // supply events override every state except STANDBY exit
      if (bat_uv_event) begin
         next_state = `ST_STANDBY;
         test_start = 1'b0;
      end else if (bat_ov_event && device_state != `ST_STANDBY) begin
         next_state = `ST_RESET;
         test_start = 1'b0;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         device_state          <= `ST_OFF;
         logic_done_seen       <= 1'b0;
         analog_self_test_fail <= 1'b0;
      end else begin
         device_state <= next_state;
         if (device_state == `ST_OFF) begin
            logic_done_seen <= 1'b0;
         end else if (logic_self_test_done) begin
            logic_done_seen <= 1'b1;
         end
         // sticky until the next run starts; a failing end wins over a start
         if (test_done && test_fail) begin
            analog_self_test_fail <= 1'b1;
         end else if (test_start) begin
            analog_self_test_fail <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // reset and enable-drive outputs
   // ****************************************************************
   reg next_reset_out;
   reg next_drive;

   always @* begin
      next_reset_out = (device_state == `ST_DIAGNOSTIC) || (device_state == `ST_ACTIVE) ||
                       (device_state == `ST_SAFE);
      if (bat_uv_event || device_state == `ST_STANDBY) begin
         next_reset_out = 1'b0;
      end
      if (bat_ov_event || device_state == `ST_RESET) begin
         next_reset_out = 1'b0;
      end
      next_drive = enable_drive_bit && (watchdog_failure_count < `WD_FAIL_LIMIT) &&
                   !internal_fault && (device_state == `ST_ACTIVE) &&
                   !bat_uv_event &&
                   !ov_live[`RAIL_XCVR] &&
                   !ov_live[`RAIL_IO];
      // every permit above must hold at once
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mcu_reset_output    <= 1'b0;
         enable_drive_output <= 1'b0;
      end else begin
         mcu_reset_output    <= next_reset_out;
         enable_drive_output <= next_drive;
      end
   end

endmodule
`default_nettype wire

// file: bench/supply_monitor_props.sv
// Purpose: port-level checks of the supply monitor block
// Assumes: one clock, rstn async active low
// Notes:   latencies of zero to three edges as handed over
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.vh"
module supply_monitor_props #(
   parameter N             = 4,
   parameter FILTER_CYCLES = 4
) (
   input wire logic         mclk,
   input wire logic         rstn,
   input wire logic [N-1:0] uv_comparator,
   input wire logic [N-1:0] ov_comparator,
   input wire logic         io_rail_5v,
   input wire logic         logic_self_test_done,
   input wire logic         logic_self_test_fail,
   input wire logic         self_test_request,
   input wire logic         diag_exit_request,
   input wire logic         restart_request,
   input wire logic         battery_overvoltage_mask,
   input wire logic         enable_drive_bit,
   input wire logic [2:0]   watchdog_failure_count,
   input wire logic         internal_fault,
   input wire logic [7:0]   monitor_status_one,
   input wire logic [7:0]   monitor_status_two,
   input wire logic [2:0]   device_state,
   input wire logic         built_in_self_test_busy,
   input wire logic         comparator_force_active,
   input wire logic         comparator_force_level,
   input wire logic         analog_self_test_fail,
   input wire logic         mcu_reset_output,
   input wire logic         enable_drive_output
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire logic permit = enable_drive_bit && watchdog_failure_count < 3'h5 && !internal_fault;

   start_test_a:
      assert property (device_state == `ST_OFF && !monitor_status_two[`STAT2_PRE_UV]
         |-> ##[1:2] device_state == `ST_SELFTEST) else $error("self-test did not start");
   test_fail_a:
      assert property ($rose(analog_self_test_fail) |-> ##[0:2] device_state == `ST_SAFE)
         else $error("failed test did not reach safe state");
   drive_permit_a:
      assert property (!$past(permit) || $past(device_state) != `ST_ACTIVE |-> !enable_drive_output)
         else $error("drive without permit");
   force_busy_a:
      assert property (comparator_force_active |-> built_in_self_test_busy) else $error("forcing while idle");
   flag_freeze_a:
      assert property (built_in_self_test_busy && $past(built_in_self_test_busy)
         |-> $stable(monitor_status_one) && $stable(monitor_status_two)) else $error("flag moved during test");
   refuse_req_a:
      assert property (self_test_request && !restart_request && !built_in_self_test_busy
         && device_state inside {`ST_SAFE, `ST_RESET} |=> !built_in_self_test_busy [*3])
         else $error("test accepted in wrong state");
   bat_uv_a:
      assert property ($rose(monitor_status_one[`STAT1_BAT_UV]) |-> ##[0:2] device_state == `ST_STANDBY
         ##1 !mcu_reset_output && !enable_drive_output) else $error("battery under reaction wrong");
   bat_ov_a:
      assert property ($rose(monitor_status_one[`STAT1_BAT_OV]) && !battery_overvoltage_mask
         && device_state inside {`ST_ACTIVE, `ST_RESET} |-> ##[0:2] device_state == `ST_RESET)
         else $error("battery over did not reset");
   ov_masked_a:
      assert property (monitor_status_one[`STAT1_BAT_OV] && battery_overvoltage_mask && device_state == `ST_ACTIVE
         |=> device_state != `ST_RESET) else $error("masked over still reset");
   ov_drive_a:
      assert property ((monitor_status_two[5] || monitor_status_two[3]) && $past(monitor_status_two[5] ||
         monitor_status_two[3]) |-> !enable_drive_output) else $error("drive high on rail over");
   io_uv_gate_a:
      assert property (!io_rail_5v && !$past(io_rail_5v) |-> !monitor_status_two[`STAT2_IO_UV])
         else $error("io under flag at 3.3 V");
   spare_bits_a:
      assert property (monitor_status_one[5:0] == 6'h00 && monitor_status_two[1:0] == 2'h0)
         else $error("spare status bit set");

   cover property ($rose(analog_self_test_fail));
   cover property (device_state == `ST_STANDBY);
   cover property (device_state == `ST_RESET);
   cover property (enable_drive_output);
endmodule

bind supply_monitor_fault_response supply_monitor_props #(.N(N), .FILTER_CYCLES(FILTER_CYCLES)) props_u (
   .mclk(mclk), .rstn(rstn), .uv_comparator(uv_comparator), .ov_comparator(ov_comparator),
   .io_rail_5v(io_rail_5v), .logic_self_test_done(logic_self_test_done),
   .logic_self_test_fail(logic_self_test_fail), .self_test_request(self_test_request),
   .diag_exit_request(diag_exit_request), .restart_request(restart_request),
   .battery_overvoltage_mask(battery_overvoltage_mask), .enable_drive_bit(enable_drive_bit),
   .watchdog_failure_count(watchdog_failure_count), .internal_fault(internal_fault),
   .monitor_status_one(monitor_status_one), .monitor_status_two(monitor_status_two),
   .device_state(device_state), .built_in_self_test_busy(built_in_self_test_busy),
   .comparator_force_active(comparator_force_active), .comparator_force_level(comparator_force_level),
   .analog_self_test_fail(analog_self_test_fail), .mcu_reset_output(mcu_reset_output),
   .enable_drive_output(enable_drive_output));
`default_nettype wire

// file: bench/rail_front_end.sv
// Purpose: comparator front end as seen by the block
// Assumes: comparators follow the emulated level at once
// Notes:   stuck holds the battery under comparator low to spoil a test
`timescale 1ns/1ps
`default_nettype none
module rail_front_end (
   input  wire logic       force_active,
   input  wire logic       force_level,
   input  wire logic       stuck,
   input  wire logic [3:0] rail_uv,
   input  wire logic [3:0] rail_ov,
   output logic      [3:0] uv_cmp,
   output logic      [3:0] ov_cmp
);
   // emulation moves only the comparator inputs, the rails keep their own state
   always_comb begin
      uv_cmp = force_active ? {4{force_level}} : rail_uv;
      ov_cmp = force_active ? {4{force_level}} : rail_ov;
      if (stuck) uv_cmp[0] = 1'b0;
   end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the supply monitor block
// Assumes: short glitch filter so rail events settle in a few cycles
// Notes:   lfsr stimulus from a fixed start, corner cases by hand
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.vh"
module tb_top;
   localparam FC = 4;
   logic        mclk, rstn, io_rail_5v, lt_done, lt_fail, mask, bit_en, fault, stuck;
   logic        busy, fa, fl, afail, mcu_rst, drv;
   logic [3:0]  rail_uv, rail_ov, uv_c, ov_c;
   logic [2:0]  wcnt, st, cmd;
   logic [7:0]  s1, s2;
   logic [31:0] rnd;
   int          failures, checks, i, r;

   rail_front_end model_u (.force_active(fa), .force_level(fl), .stuck(stuck), .rail_uv(rail_uv),
      .rail_ov(rail_ov), .uv_cmp(uv_c), .ov_cmp(ov_c));
   supply_monitor_fault_response #(.N(4), .FILTER_CYCLES(FC)) dut_u (
      .mclk(mclk), .rstn(rstn), .uv_comparator(uv_c), .ov_comparator(ov_c), .io_rail_5v(io_rail_5v),
      .logic_self_test_done(lt_done), .logic_self_test_fail(lt_fail), .self_test_request(cmd[0]),
      .diag_exit_request(cmd[1]), .restart_request(cmd[2]), .battery_overvoltage_mask(mask),
      .enable_drive_bit(bit_en), .watchdog_failure_count(wcnt), .internal_fault(fault),
      .monitor_status_one(s1), .monitor_status_two(s2), .device_state(st),
      .built_in_self_test_busy(busy), .comparator_force_active(fa), .comparator_force_level(fl),
      .analog_self_test_fail(afail), .mcu_reset_output(mcu_rst), .enable_drive_output(drv));

   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_two(input logic [3:0] u, o, input logic v5);
      return {o[1], u[1], o[2], u[2], o[3], u[3] & v5, 2'b00};
   endfunction
   function automatic logic exp_drive(input logic b, input logic [2:0] c, input logic f, input logic [3:0] o);
      return b & (c < 3'h5) & ~f & ~o[2] & ~o[3];
   endfunction
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic look;
      @(negedge mclk);
   endtask
   task automatic pulse(input logic [2:0] c);
      cmd <= c;
      cyc(1);
      cmd <= 3'h0;
   endtask
   // requests only once the self-test has let go of busy
   task automatic idle(input logic [2:0] want);
      int k;
      cyc(20);
      for (k = 0; k < 3000 && busy !== 1'b0; k++) cyc(1);
      cyc(3);
      look;
      chk("busy", 8'(busy), 8'h00);
      chk("state", 8'(st), 8'(want));
      chk("force", {6'h00, fa, fl}, 8'h00);
   endtask
   task automatic end_sim;
      if (failures == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      cyc(40000);
      failures++;
      end_sim;
   end

   // ****************
   // scenarios
   // ****************
   initial begin
      {rstn, io_rail_5v, lt_done, lt_fail, mask, bit_en, fault, stuck} <= 8'b01100000;
      {rail_uv, rail_ov, wcnt, cmd} <= 14'h0000;
      rnd = 32'h9453122b;
      cyc(11);
      look;
      chk("state", 8'(st), 8'(`ST_OFF));
      chk("reset out", 8'(mcu_rst), 8'h00);
      cyc(1);
      rstn <= 1'b1;
      cyc(2);
      look;
      chk("state", 8'(st), 8'(`ST_SELFTEST));
      idle(`ST_DIAGNOSTIC);
      chk("status one", s1, 8'h00);
      chk("reset out", 8'(mcu_rst), 8'h01);
      cyc(1);
      pulse(3'h2);
      cyc(3);
      look;
      chk("state", 8'(st), 8'(`ST_ACTIVE));
      for (i = 0; i < 24; i++) begin
         cyc(1);
         rnd = lfsr(rnd);
         bit_en <= (rnd[0] | (i < 2)) & (bit_en | (rnd[3:1] < 3'h5) | (i == 0));
         wcnt <= (i < 2) ? 3'h4 + 3'(i) : rnd[3:1];
         fault <= rnd[4] & (i > 3);
         cyc(4);
         look;
         chk("drive", 8'(drv), 8'(exp_drive(bit_en, wcnt, fault, rail_ov)));
      end
      cyc(1);
      {bit_en, wcnt, fault} <= 5'b10000;
      for (i = 0; i < 7; i++) begin
         r = (i == 6) ? 3 : i % 3 + 1;
         cyc(1);
         io_rail_5v <= (i != 6);
         rail_uv <= (i < 3 || i == 6) ? 4'h1 << r : 4'h0;
         rail_ov <= (i > 2 && i < 6) ? 4'h1 << r : 4'h0;
         cyc(FC + 8);
         look;
         chk("status two", s2, exp_two(rail_uv, rail_ov, io_rail_5v));
         chk("drive", 8'(drv), 8'(exp_drive(bit_en, wcnt, fault, rail_ov)));
         chk("state", 8'(st), 8'(`ST_ACTIVE));
         cyc(1);
         {rail_uv, rail_ov} <= 8'h00;
         cyc(FC + 8);
         look;
         chk("status two", s2, 8'h00);
      end
      cyc(1);
      rail_uv <= 4'h4;
      cyc(2);
      rail_uv <= 4'h0;
      cyc(FC + 8);
      look;
      chk("status two", s2, 8'h00);
      cyc(1);
      pulse(3'h1);
      cyc(30);
      look;
      chk("busy", 8'(busy), 8'h01);
      chk("force", {6'h00, fa, fl}, 8'h02);
      chk("status one", s1, 8'h00);
      chk("state", 8'(st), 8'(`ST_ACTIVE));
      idle(`ST_ACTIVE);
      chk("analog fail", 8'(afail), 8'h00);
      cyc(1);
      mask <= 1'b1;
      rail_ov <= 4'h1;
      cyc(FC + 8);
      look;
      chk("status one", s1, 8'h80);
      chk("state", 8'(st), 8'(`ST_ACTIVE));
      cyc(1);
      {mask, rail_ov} <= 5'h00;
      cyc(FC + 8);
      rail_ov <= 4'h1;
      cyc(FC + 8);
      look;
      chk("state", 8'(st), 8'(`ST_RESET));
      cyc(1);
      rail_ov <= 4'h0;
      pulse(3'h1);
      cyc(FC + 8);
      look;
      chk("busy", 8'(busy), 8'h00);
      cyc(1);
      pulse(3'h4);
      idle(`ST_DIAGNOSTIC);
      cyc(1);
      stuck <= 1'b1;
      pulse(3'h1);
      idle(`ST_SAFE);
      chk("analog fail", 8'(afail), 8'h01);
      cyc(1);
      stuck <= 1'b0;
      pulse(3'h4);
      idle(`ST_DIAGNOSTIC);
      cyc(1);
      rail_uv <= 4'h1;
      cyc(FC + 8);
      look;
      chk("status one", s1, 8'h40);
      chk("state", 8'(st), 8'(`ST_STANDBY));
      chk("outputs", {6'h00, mcu_rst, drv}, 8'h00);
      cyc(1);
      rail_uv <= 4'h0;
      idle(`ST_DIAGNOSTIC);
      cyc(1);
      rstn <= 1'b0;
      {lt_done, lt_fail} <= 2'b01;
      cyc(3);
      rstn <= 1'b1;
      cyc(9);
      look;
      chk("state", 8'(st), 8'(`ST_SELFTEST));
      cyc(1);
      lt_done <= 1'b1;
      idle(`ST_SAFE);
      end_sim;
   end
endmodule
`default_nettype wire
